// ===== asr_regs.sv
`timescale 1ns/1ps
module asr_regs (
    input  wire logic        clk,
    input  wire logic        nrst,
    // Host register port
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    output logic             reg_rvalid,
    // Nonvolatile shadow read port
    output logic             nv_req,
    output logic      [15:0] nv_addr,
    input  wire logic        nv_ack,
    input  wire logic [7:0]  nv_data,
    output logic             preload_done,
    // Fault and status sources (asynchronous)
    input  wire logic        ov_fault,
    input  wire logic        uv_fault,
    input  wire logic        ocp_timeout,
    input  wire logic        ac_sense_good,
    input  wire logic        ocp_flag,
    input  wire logic        over_temp,
    input  wire logic        orfet_good,
    input  wire logic        load_sharing_bad,
    input  wire logic        supply_good,
    input  wire logic [3:0]  monitor_flags,
    input  wire logic        monitor_input_five,
    // Outputs
    output logic      [7:0]  clamp_level,
    output logic      [7:0]  setpoint_code,
    output logic             alert_output_pin
);

    // ------------------------------------------------------------
    // Source synchronisers
    // ------------------------------------------------------------
    logic [13:0] src_raw;
    logic [13:0] src_s1;
    logic [13:0] src_s2;

    assign src_raw = {ov_fault, uv_fault, ocp_timeout, ac_sense_good, ocp_flag,
                      over_temp, orfet_good, load_sharing_bad, supply_good,
                      monitor_flags, monitor_input_five};

    // Two flops per source
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            src_s1 <= 14'h0000;
            src_s2 <= 14'h0000;
        end else begin
            src_s1 <= src_raw;
            src_s2 <= src_s1;
        end
    end

    // ------------------------------------------------------------
    // Register store
    // ------------------------------------------------------------
    logic        mem_wr;
    logic [1:0]  mem_widx;
    logic [7:0]  mem_wdata;
    logic [1:0]  mem_ridx;
    logic [7:0]  mem_rdata;
    logic [31:0] mem_all;
    logic [7:0]  alert_mask_first;
    logic [7:0]  alert_mask_second;

    asr_shadow_mem #(.DEPTH(4)) u_mem (
        .clk      (clk),
        .nrst     (nrst),
        .wr_en    (mem_wr),
        .wr_idx   (mem_widx),
        .wr_data  (mem_wdata),
        .rd_idx   (mem_ridx),
        .rd_data  (mem_rdata),
        .all_data (mem_all)
    );

    assign alert_mask_first  = mem_all[23:16];
    assign alert_mask_second = mem_all[31:24];

    // ------------------------------------------------------------
    // Preload sequencer
    // ------------------------------------------------------------
    asr_pkg::asr_state_t state;
    logic [1:0]          load_idx;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state    <= asr_pkg::ASR_IDLE;
            load_idx <= 2'h0;
        end else begin
            case (state)
                asr_pkg::ASR_IDLE: begin
                    state <= asr_pkg::ASR_REQ;
                end
                asr_pkg::ASR_REQ: begin
                    state <= asr_pkg::ASR_WAIT;
                end
                asr_pkg::ASR_WAIT: begin
                    if (nv_ack) begin
                        if (load_idx == asr_pkg::LOAD_CNT) begin
                            state <= asr_pkg::ASR_DONE;
                        end else begin
                            load_idx <= load_idx + 2'h1;
                            state    <= asr_pkg::ASR_REQ;
                        end
                    end
                end
                default: begin
                    state <= asr_pkg::ASR_DONE;
                end
            endcase
        end
    end

    // Shadow address for each slot
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            nv_req       <= 1'b0;
            nv_addr      <= asr_pkg::NV_CLAMP;
            preload_done <= 1'b0;
        end else begin
            nv_req       <= (state == asr_pkg::ASR_REQ);
            preload_done <= (state == asr_pkg::ASR_DONE);
            case (load_idx)
                2'h0:    nv_addr <= asr_pkg::NV_CLAMP;
                2'h1:    nv_addr <= asr_pkg::NV_SETPT;
                2'h2:    nv_addr <= asr_pkg::NV_SEL_A;
                default: nv_addr <= asr_pkg::NV_SEL_B;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Host access decode
    // ------------------------------------------------------------
    logic       host_hit;
    logic [1:0] host_idx;
    logic       loading;

    always_comb begin
        host_hit = 1'b1;
        if (reg_addr == asr_pkg::OFS_CLAMP) begin
            host_idx = 2'h0;
        end else if (reg_addr == asr_pkg::OFS_SETPT) begin
            host_idx = 2'h1;
        end else if (reg_addr == asr_pkg::OFS_SEL_A) begin
            host_idx = 2'h2;
        end else if (reg_addr == asr_pkg::OFS_SEL_B) begin
            host_idx = 2'h3;
        end else begin
            host_idx = 2'h0;
            host_hit = 1'b0;
        end
    end

    assign loading   = (state != asr_pkg::ASR_DONE);
    // Preload owns the store; host writes made during preload are dropped
    assign mem_wr    = loading ? (state == asr_pkg::ASR_WAIT && nv_ack)
                               : (reg_wr && host_hit);
    assign mem_widx  = loading ? load_idx : host_idx;
    assign mem_wdata = loading ? nv_data : reg_wdata;
    assign mem_ridx  = host_idx;

    // Read answer two cycles after the read request
    logic rd_pend;
    logic rd_hit;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_pend <= 1'b0;
            rd_hit  <= 1'b0;
        end else begin
            rd_pend <= reg_rd;
            rd_hit  <= host_hit;
        end
    end

    // Unmapped reads return zero; answer leaves a flop
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata  <= rd_hit ? mem_rdata : 8'h00;
            reg_rvalid <= rd_pend;
        end
    end

    // ------------------------------------------------------------
    // Trim outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            clamp_level   <= asr_pkg::RST_REG;
            setpoint_code <= asr_pkg::RST_REG;
        end else begin
            clamp_level   <= mem_all[7:0];
            setpoint_code <= mem_all[15:8];
        end
    end

    // ------------------------------------------------------------
    // Alert combine
    // ------------------------------------------------------------
    logic [7:0] act_a;
    logic [7:0] act_b;

    // Active-high view of each source
    always_comb begin
        act_a = {src_s2[13], src_s2[12], src_s2[11], ~src_s2[10], src_s2[9],
                 src_s2[8], ~src_s2[7], src_s2[6]};
        act_b = {~src_s2[5], src_s2[4:1], 1'b1, src_s2[0], 1'b0};
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            alert_output_pin <= 1'b0;
        end else begin
            alert_output_pin <= |(act_a & alert_mask_first)
                              | |(act_b & alert_mask_second);
        end
    end

endmodule

// ===== asr_pkg.sv
package asr_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CLAMP   = 8'h18;
    localparam logic [7:0] OFS_SETPT   = 8'h19;
    localparam logic [7:0] OFS_SEL_A   = 8'h1A;
    localparam logic [7:0] OFS_SEL_B   = 8'h1B;

    // ------------------------------------------------------------
    // Shadow locations in nonvolatile store
    // ------------------------------------------------------------
    localparam logic [15:0] NV_CLAMP   = 16'h8118;
    localparam logic [15:0] NV_SETPT   = 16'h8119;
    localparam logic [15:0] NV_SEL_A   = 16'h811A;
    localparam logic [15:0] NV_SEL_B   = 16'h811B;

    // ------------------------------------------------------------
    // Reset values before preload and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] RST_REG     = 8'h00;
    localparam int         BIT_HOST_DRV = 2;
    localparam int         BIT_UNUSED   = 0;
    localparam logic [1:0] LOAD_CNT    = 2'h3;

    // Preload sequencer states
    typedef enum logic [1:0] {
        ASR_IDLE = 2'b00,
        ASR_REQ  = 2'b01,
        ASR_WAIT = 2'b10,
        ASR_DONE = 2'b11
    } asr_state_t;

endpackage

// ===== asr_shadow_mem.sv
`timescale 1ns/1ps
module asr_shadow_mem #(
    parameter int DEPTH = 4
) (
    input  wire logic                     clk,
    input  wire logic                     nrst,
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
    input  wire logic [7:0]               wr_data,
    input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
    output logic      [7:0]               rd_data,
    output logic      [DEPTH*8-1:0]       all_data
);

    localparam int IDXW = $clog2(DEPTH);

    logic [7:0] mem [DEPTH];

    // ------------------------------------------------------------
    // Storage, one generate entry per register
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_ent
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    mem[g] <= asr_pkg::RST_REG;
                end else if (wr_en && wr_idx == IDXW'(g)) begin
                    mem[g] <= wr_data;
                end
            end
            assign all_data[g*8 +: 8] = mem[g];
        end
    endgenerate

    // Registered read port
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_data <= asr_pkg::RST_REG;
        end else begin
            rd_data <= mem[rd_idx];
        end
    end

endmodule

// ===== asr_nv_model.sv
`timescale 1ns/1ps
module asr_nv_model (
    input  wire logic        clk,
    input  wire logic        slow,
    input  wire logic        nv_req,
    input  wire logic [15:0] nv_addr,
    output logic             nv_ack,
    output logic [7:0]       nv_data
);
    // ----
    // Shadow store answering preload reads
    // ----
    logic [3:0]  cnt = 4'h0;
    logic        pend = 1'b0;
    logic [15:0] addr_q = 16'h0000;
    initial nv_ack = 1'b0;
    initial nv_data = 8'h00;
    // Take the request pulse, answer after a prompt or slow wait, then scramble the data
    always @(posedge clk) begin
        if (nv_req) begin
            pend   <= 1'b1;
            addr_q <= nv_addr;
            cnt    <= 4'h0;
            nv_ack <= 1'b0;
        end else if (pend && cnt >= (slow ? 4'h5 : 4'h0)) begin
            nv_ack <= 1'b1;
            pend   <= 1'b0;
            case (addr_q)
                16'h8118: nv_data <= 8'ha5;
                16'h8119: nv_data <= 8'h3c;
                16'h811a: nv_data <= 8'h40;
                default:  nv_data <= 8'h01;
            endcase
        end else begin
            nv_ack <= 1'b0;
            nv_data <= ~nv_data;
            cnt <= pend ? cnt + 4'h1 : 4'h0;
        end
    end
endmodule

// ===== asr_regs_asserts.sv
`timescale 1ns/1ps
module asr_regs_asserts (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        nv_req,
    input wire logic [15:0] nv_addr,
    input wire logic        nv_ack,
    input wire logic [7:0]  nv_data,
    input wire logic        preload_done,
    input wire logic        ov_fault,
    input wire logic        uv_fault,
    input wire logic        ocp_timeout,
    input wire logic        ac_sense_good,
    input wire logic        ocp_flag,
    input wire logic        over_temp,
    input wire logic        orfet_good,
    input wire logic        load_sharing_bad,
    input wire logic        supply_good,
    input wire logic [3:0]  monitor_flags,
    input wire logic        monitor_input_five,
    input wire logic [7:0]  clamp_level,
    input wire logic [7:0]  setpoint_code,
    input wire logic        alert_output_pin
);
    // ----
    // Register copies and expected alert
    // ----
    logic [7:0]  trk [4];
    logic        ex;
    logic [13:0] fl_d1;
    logic [13:0] fl_d2;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Follow preload answers and host writes
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 4; i++) trk[i] <= 8'h00;
        end else if (nv_ack && !preload_done) begin
            trk[nv_addr[1:0]] <= nv_data;
        end else if (reg_wr && reg_addr[7:2] == 6'h06) begin
            trk[reg_addr[1:0]] <= reg_wdata;
        end
    end
    // Two-stage copy of the source pins, as the pin path synchronises them
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fl_d1 <= 14'h0000;
            fl_d2 <= 14'h0000;
        end else begin
            fl_d1 <= {ov_fault, uv_fault, ocp_timeout, ac_sense_good, ocp_flag, over_temp,
                      orfet_good, load_sharing_bad, supply_good, monitor_flags,
                      monitor_input_five};
            fl_d2 <= fl_d1;
        end
    end
    // Enabled sources ORed, bit 0 of mask b left out
    assign ex = |(trk[2] & {fl_d2[13:11], ~fl_d2[10], fl_d2[9:8], ~fl_d2[7], fl_d2[6]})
              | |(trk[3][7:1] & {~fl_d2[5], fl_d2[4:1], 1'b1, fl_d2[0]});
    // ----
    // Checks
    // ----
    AST_NV_ADDR: assert property (nv_req |-> nv_addr inside {[16'h8118:16'h811b]})
        else $error("preload address outside shadow slots");
    AST_PRELOAD: assert property ($rose(nrst) |-> ##[1:100] preload_done)
        else $error("preload did not finish");
    AST_DONE_HOLD: assert property (preload_done |=> preload_done)
        else $error("preload done dropped");
    AST_NV_IDLE: assert property (preload_done |-> !nv_req)
        else $error("store read after preload");
    AST_ALERT_OR: assert property (preload_done && $past(preload_done) |->
        alert_output_pin == $past(ex))
        else $error("alert differs from enabled sources");
    AST_HOST_DRV: assert property (preload_done && trk[3][2] && $past(trk[3][2])
        && $past(trk[3][2], 2) |-> alert_output_pin)
        else $error("host drive bit did not raise alert");
    AST_QUIET: assert property (preload_done && $past(preload_done) && !$past(ex)
        |-> !alert_output_pin)
        else $error("alert held with no source");
    AST_CLAMP: assert property (preload_done && $stable(trk[0]) && $past(trk[0]) ==
        $past(trk[0], 2) |-> clamp_level == trk[0])
        else $error("clamp output differs from register");
    AST_SETPT: assert property (preload_done && $stable(trk[1]) && $past(trk[1]) ==
        $past(trk[1], 2) |-> setpoint_code == trk[1])
        else $error("setpoint output differs from register");
    COV_HOST: cover property (preload_done && trk[3][2] ##2 alert_output_pin);
    COV_ALERT: cover property ($rose(alert_output_pin));
    COV_LOAD: cover property (nv_ack && !preload_done);
endmodule
bind asr_regs asr_regs_asserts u_asr_regs_asserts (.*);

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
    // ----
    // Stimulus and design
    // ----
    typedef struct {logic [7:0] a; logic [7:0] b; logic [13:0] f; logic e;} asr_row_t;
    logic        clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, rd_v;
    logic [13:0] fl = 14'h04a0;
    logic [15:0] nv_addr;
    logic [7:0]  reg_rdata, nv_data, clamp_level, setpoint_code;
    logic        reg_rvalid, nv_req, nv_ack, preload_done, alert_output_pin;
    int          failures = 0, compares = 0, cyc = 0;
    asr_row_t    rows [16] = '{'{8'h80, 8'h00, 14'h24a0, 1'b1}, '{8'h40, 8'h00, 14'h14a0, 1'b1},
        '{8'h20, 8'h00, 14'h0ca0, 1'b1}, '{8'h10, 8'h00, 14'h00a0, 1'b1},
        '{8'h08, 8'h00, 14'h06a0, 1'b1}, '{8'h04, 8'h00, 14'h05a0, 1'b1},
        '{8'h02, 8'h00, 14'h0420, 1'b1}, '{8'h01, 8'h00, 14'h04e0, 1'b1},
        '{8'h7f, 8'h00, 14'h24a0, 1'b0}, '{8'h00, 8'h80, 14'h0480, 1'b1},
        '{8'h00, 8'h78, 14'h04a2, 1'b1}, '{8'h00, 8'h78, 14'h04b0, 1'b1},
        '{8'h00, 8'h02, 14'h04a1, 1'b1}, '{8'h00, 8'h01, 14'h3b5f, 1'b0},
        '{8'h00, 8'h04, 14'h04a0, 1'b1}, '{8'h00, 8'h00, 14'h3b5f, 1'b0}};
    asr_regs u_asr_regs (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .nv_req(nv_req), .nv_addr(nv_addr), .nv_ack(nv_ack),
        .nv_data(nv_data), .preload_done(preload_done), .ov_fault(fl[13]),
        .uv_fault(fl[12]), .ocp_timeout(fl[11]), .ac_sense_good(fl[10]), .ocp_flag(fl[9]),
        .over_temp(fl[8]), .orfet_good(fl[7]), .load_sharing_bad(fl[6]),
        .supply_good(fl[5]), .monitor_flags(fl[4:1]), .monitor_input_five(fl[0]),
        .clamp_level(clamp_level), .setpoint_code(setpoint_code),
        .alert_output_pin(alert_output_pin));
    asr_nv_model u_asr_nv_model (.clk(clk), .slow(slow), .nv_req(nv_req),
        .nv_addr(nv_addr), .nv_ack(nv_ack), .nv_data(nv_data));
    // Clock and hang limit
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            close_out();
        end
    end
    // ----
    // Tasks
    // ----
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        @(negedge clk);
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        int n;
        n = 0;
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        while (reg_rvalid !== 1'b1 && n < 8) begin
            n++;
            @(negedge clk);
        end
        rd_v = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
        reg_rd = 1'b0;
        chk("register read", rd_v, e);
        @(negedge clk);
    endtask
    task automatic boot();
        int n;
        n = 0;
        nrst = 1'b0;
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        while (preload_done !== 1'b1 && n < 200) begin
            n++;
            @(negedge clk);
        end
        chk("preload done", {7'h00, preload_done}, 8'h01);
    endtask
    task automatic close_out();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ----
    // Sequence
    // ----
    initial begin
        boot();
        foreach (rows[i]) begin
            fl = rows[i].f;
            wr(8'h1a, rows[i].a);
            wr(8'h1b, rows[i].b);
            @(negedge clk);
            chk("alert", {7'h00, alert_output_pin}, {7'h00, rows[i].e});
            $display("row %0d done", i);
        end
        wr(8'h19, 8'h5a);
        rc(8'h19, 8'h5a);
        chk("setpoint", setpoint_code, 8'h5a);
        wr(8'h18, 8'hff);
        @(negedge clk);
        chk("clamp", clamp_level, 8'hff);
        $display("trim test done");
        fl = 14'h04a0;
        wr(8'h1b, 8'h04);
        chk("alert host drive", {7'h00, alert_output_pin}, 8'h01);
        wr(8'h1b, 8'h00);
        @(negedge clk);
        chk("alert release", {7'h00, alert_output_pin}, 8'h00);
        $display("host drive test done");
        slow = 1'b1;
        boot();
        rc(8'h18, 8'ha5);
        rc(8'h19, 8'h3c);
        rc(8'h1a, 8'h40);
        rc(8'h1b, 8'h01);
        chk("clamp", clamp_level, 8'ha5);
        chk("setpoint", setpoint_code, 8'h3c);
        chk("alert", {7'h00, alert_output_pin}, 8'h00);
        $display("preload test done");
        close_out();
    end
endmodule
